// ==== rtl/adcrb_dma.sv ====
`timescale 1ns/1ps
// Behaviour
// - buffer-reset write resets engine, bit self-clears
// - linear mode stops when buffer full
// - circular mode restarts at start after last
// - arm one starts engine, zero ignored
// - arm clears on start or reset
// - result while inactive sets dropped flag
// - dropped flag held until buffer reset
// - active flag reads engine activity, read-only
// - start address lsb forced to zero
// - length counts 16-bit results, not bytes
// - write pointer shows next write location
// - fill count shows results written
// - half and full pending flags set
// - overrun, saturation, ready pending flags set
// - enable bits gate events onto interrupt
// - run bit keeps converter producing results
module adcrb_dma (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic conv_run,
  input wire logic result_valid,
  input wire logic [adcrb_pkg::DATA_W-1:0] result_data,
  input wire logic result_saturated,
  output adcrb_pkg::adcrb_ram_wr_t ram_wr,
  output logic irq
);

  logic arm_reg;
  logic wrap_reg;
  logic run_reg;
  logic active_reg;
  logic dropped_reg;
  logic [adcrb_pkg::ADDR_W-1:0] start_reg;
  logic [adcrb_pkg::LEN_W-1:0] len_reg;
  logic [adcrb_pkg::ADDR_W-2:0] cur_reg;
  logic [adcrb_pkg::LEN_W-1:0] cnt_reg;
  logic [adcrb_pkg::EV_W-1:0] pend_reg;
  logic [adcrb_pkg::EV_W-1:0] en_reg;
  logic [31:0] prdata_reg;
  adcrb_pkg::adcrb_ram_wr_t ram_wr_reg;

  // bus decode
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire hit_pend = paddr == adcrb_pkg::ADDR_EVENT_PENDING;
  wire hit_clr = paddr == adcrb_pkg::ADDR_EVENT_CLEAR;
  wire hit_en = paddr == adcrb_pkg::ADDR_EVENT_ENABLE;
  wire hit_run = paddr == adcrb_pkg::ADDR_CONV_CONTROL;
  wire hit_ctl = paddr == adcrb_pkg::ADDR_BUF_CONTROL;
  wire hit_st = paddr == adcrb_pkg::ADDR_BUF_STATE;
  wire hit_beg = paddr == adcrb_pkg::ADDR_BUF_START;
  wire hit_len = paddr == adcrb_pkg::ADDR_BUF_LENGTH;
  wire hit_ptr = paddr == adcrb_pkg::ADDR_BUF_WPTR;
  wire hit_cnt = paddr == adcrb_pkg::ADDR_BUF_COUNT;
  wire hit_any = hit_pend || hit_clr || hit_en || hit_run || hit_ctl ||
                 hit_st || hit_beg || hit_len || hit_ptr || hit_cnt;
  wire hit_ro = hit_st || hit_ptr || hit_cnt;
  wire hit_wo = hit_clr;
  wire bad = !hit_any || (pwrite && hit_ro) || (!pwrite && hit_wo);

  // commands
  wire wr_ctl = wr_acc && hit_ctl;
  wire buf_reset = wr_ctl && pwdata[adcrb_pkg::CTL_RESET_BIT];
  wire arm_set = wr_ctl && pwdata[adcrb_pkg::CTL_ARM_BIT];
  wire start_go = arm_reg && !active_reg && !buf_reset;

  // engine datapath
  wire result_in = result_valid && run_reg;
  wire accept = result_in && active_reg;
  wire dropped_ev = result_in && !active_reg;
  wire [adcrb_pkg::LEN_W-1:0] cnt_next = cnt_reg + adcrb_pkg::CNT_STEP;
  wire [adcrb_pkg::ADDR_W-2:0] cur_inc =
    cur_reg + {{(adcrb_pkg::ADDR_W-2){1'b0}}, 1'b1};
  wire [adcrb_pkg::ADDR_W-2:0] start_word = start_reg[adcrb_pkg::ADDR_W-1:1];
  wire buf_full = cnt_next >= len_reg;
  wire [adcrb_pkg::LEN_W-1:0] half_len = len_reg >> 1;
  wire half_hit = accept && (half_len != adcrb_pkg::CNT_ZERO) &&
                  (cnt_next == half_len);
  wire full_hit = accept && buf_full;
  wire [31:0] ram_addr = {adcrb_pkg::RAM_BASE_HI, cur_reg, 1'b0};

  // events
  wire [adcrb_pkg::EV_W-1:0] ev_set = {dropped_ev, result_saturated,
                                       full_hit, half_hit, accept};
  wire [adcrb_pkg::EV_W-1:0] ev_clr =
    (wr_acc && (hit_pend || hit_clr)) ? pwdata[adcrb_pkg::EV_W-1:0] :
    {adcrb_pkg::EV_W{1'b0}};
  wire [adcrb_pkg::EV_W-1:0] pend_next = ev_set | (pend_reg & ~ev_clr);
  wire half_clr = ev_clr[adcrb_pkg::EV_HALF_BIT];

  // read mux
  wire [31:0] rd_ctl = {30'h0, wrap_reg, arm_reg};
  wire [31:0] rd_st = {30'h0, dropped_reg, active_reg};
  wire [31:0] rd_ptr = ram_addr;
  wire [31:0] rd_cnt = {19'h0, cnt_reg};
  wire [31:0] rd_data =
    hit_pend ? {27'h0, pend_reg} :
    hit_en ? {27'h0, en_reg} :
    hit_run ? {31'h0, run_reg} :
    hit_ctl ? rd_ctl :
    hit_st ? rd_st :
    hit_beg ? (adcrb_pkg::RAM_BASE | {18'h0, start_reg}) :
    hit_len ? {19'h0, len_reg} :
    hit_ptr ? rd_ptr :
    hit_cnt ? rd_cnt : 32'h0;

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad;
  assign conv_run = run_reg;
  assign ram_wr = ram_wr_reg;
  assign irq = |(pend_reg & en_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_reg <= rd_data;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_reg <= 1'b0;
      run_reg <= 1'b0;
      start_reg <= {adcrb_pkg::ADDR_W{1'b0}};
      len_reg <= adcrb_pkg::CNT_ZERO;
      en_reg <= {adcrb_pkg::EV_W{1'b0}};
      pend_reg <= {adcrb_pkg::EV_W{1'b0}};
    end else begin
      pend_reg <= pend_next;
      if (wr_ctl) begin
        wrap_reg <= pwdata[adcrb_pkg::CTL_WRAP_BIT];
      end
      if (wr_acc && hit_run) begin
        run_reg <= pwdata[adcrb_pkg::RUN_BIT];
      end
      if (wr_acc && hit_beg) begin
        start_reg <= {pwdata[adcrb_pkg::ADDR_W-1:1], 1'b0};
      end
      if (wr_acc && hit_len) begin
        len_reg <= pwdata[adcrb_pkg::LEN_W-1:0];
      end
      if (wr_acc && hit_en) begin
        en_reg <= pwdata[adcrb_pkg::EV_W-1:0];
      end
    end
  end

  // arm bit and dropped flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg <= 1'b0;
      dropped_reg <= 1'b0;
    end else begin
      if (buf_reset || start_go) begin
        arm_reg <= 1'b0;
      end else if (arm_set) begin
        arm_reg <= 1'b1;
      end
      if (buf_reset) begin
        dropped_reg <= 1'b0;
      end else if (dropped_ev) begin
        dropped_reg <= 1'b1;
      end
    end
  end

  // transfer engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 1'b0;
      cur_reg <= {(adcrb_pkg::ADDR_W-1){1'b0}};
      cnt_reg <= adcrb_pkg::CNT_ZERO;
    end else if (buf_reset) begin
      active_reg <= 1'b0;
      cur_reg <= start_word;
      cnt_reg <= adcrb_pkg::CNT_ZERO;
    end else if (start_go) begin
      active_reg <= 1'b1;
      cur_reg <= start_word;
      cnt_reg <= adcrb_pkg::CNT_ZERO;
    end else if (accept && buf_full && wrap_reg) begin
      cur_reg <= start_word;
      cnt_reg <= adcrb_pkg::CNT_ZERO;
    end else if (accept) begin
      active_reg <= !buf_full;
      cur_reg <= cur_inc;
      cnt_reg <= cnt_next;
    end
  end

  // ram write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_wr_reg <= '0;
    end else begin
      ram_wr_reg.en <= accept;
      if (accept) begin
        ram_wr_reg.addr <= ram_addr;
        ram_wr_reg.data <= result_data;
      end
    end
  end

  // elaboration checks on the package geometry
  if (adcrb_pkg::ADDR_W != adcrb_pkg::LEN_W + 1) begin : g_check_width
    $error("pointer field must be one bit wider than count");
  end
  if ((32'(adcrb_pkg::RAM_BASE_HI) << adcrb_pkg::ADDR_W) !=
      adcrb_pkg::RAM_BASE) begin : g_check_base
    $error("ram base high part does not match ram base");
  end
  if (adcrb_pkg::EV_OVR_BIT >= adcrb_pkg::EV_W) begin : g_check_events
    $error("event bit outside event vector");
  end

  // engine reset and stop
  a_reset_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    buf_reset
    |=> !active_reg && !arm_reg && !dropped_reg)
    else $error("buffer reset did not clear engine");
  a_reset_rewind: assert property (
    @(posedge pclk) disable iff (!presetn)
    buf_reset
    |=> cnt_reg == adcrb_pkg::CNT_ZERO && cur_reg == $past(start_word))
    else $error("buffer reset did not rewind pointer");
  a_linear_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && buf_full && !wrap_reg && !buf_reset
    |=> !active_reg)
    else $error("linear mode kept running when full");
  a_idle_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    !active_reg
    |=> !ram_wr.en)
    else $error("ram written while engine idle");
  a_wrap_restart: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && buf_full && wrap_reg && !buf_reset
    |=> active_reg && cnt_reg == adcrb_pkg::CNT_ZERO)
    else $error("circular mode did not restart");
  a_wrap_rewind: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && buf_full && wrap_reg && !buf_reset
    |=> cur_reg == $past(start_word))
    else $error("circular mode did not return to start");

  // arm bit
  a_arm_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    arm_set && !active_reg && !buf_reset
    |=> ##1 active_reg)
    else $error("arm did not start engine");
  a_arm_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    arm_set && !buf_reset && !start_go
    |=> arm_reg)
    else $error("arm write did not set arm bit");
  a_arm_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctl && !pwdata[adcrb_pkg::CTL_ARM_BIT] && !buf_reset &&
    !arm_reg && !active_reg
    |=> !arm_reg && !active_reg)
    else $error("arm write of zero had an effect");
  a_arm_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(active_reg)
    |-> !arm_reg)
    else $error("arm stayed set after start");

  // status flags
  a_dropped_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    dropped_ev && !buf_reset
    |=> dropped_reg && pend_reg[adcrb_pkg::EV_OVR_BIT])
    else $error("dropped result not flagged");
  a_dropped_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    dropped_reg && !buf_reset
    |=> dropped_reg)
    else $error("dropped flag cleared without buffer reset");
  a_active_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_st
    |=> prdata[adcrb_pkg::ST_ACTIVE_BIT] == $past(active_reg) &&
        prdata[adcrb_pkg::ST_DROPPED_BIT] == $past(dropped_reg))
    else $error("state read does not match engine");
  a_start_even: assert property (
    @(posedge pclk) disable iff (!presetn)
    !start_reg[0])
    else $error("start address odd");

  // counting and pointer
  a_linear_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && !wrap_reg && !buf_reset && cnt_next == len_reg
    |=> cnt_reg == $past(len_reg))
    else $error("linear fill count differs from length");
  a_ptr_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_ptr
    |=> prdata[adcrb_pkg::ADDR_W-1:1] == $past(cur_reg) &&
        !prdata[0])
    else $error("pointer read does not show next location");
  a_count_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_cnt
    |=> prdata[adcrb_pkg::LEN_W-1:0] == $past(cnt_reg))
    else $error("count read does not match results written");
  a_ptr_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && !buf_full && !buf_reset
    |=> cur_reg == $past(cur_reg) + 1'h1 &&
        cnt_reg == $past(cnt_reg) + adcrb_pkg::CNT_STEP)
    else $error("pointer or count did not step");
  a_ram_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept
    |=> ram_wr.en && ram_wr.addr == $past(ram_addr) &&
        ram_wr.data == $past(result_data))
    else $error("ram write mismatch");
  a_ram_base: assert property (
    @(posedge pclk) disable iff (!presetn)
    ram_wr.en
    |-> (ram_wr.addr >> adcrb_pkg::ADDR_W) == 32'(adcrb_pkg::RAM_BASE_HI))
    else $error("ram write outside ram window");

  // pending flags and interrupt
  a_half_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    half_hit |=> pend_reg[adcrb_pkg::EV_HALF_BIT]
    ##1 (pend_reg[adcrb_pkg::EV_HALF_BIT] || $past(half_clr)))
    else $error("half flag not set");
  a_full_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    full_hit
    |=> pend_reg[adcrb_pkg::EV_FULL_BIT])
    else $error("full flag not set");
  a_pend_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    pend_reg[adcrb_pkg::EV_FULL_BIT] && !ev_clr[adcrb_pkg::EV_FULL_BIT]
    |=> pend_reg[adcrb_pkg::EV_FULL_BIT])
    else $error("full flag dropped without clear");
  a_sat_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    result_saturated
    |=> pend_reg[adcrb_pkg::EV_SAT_BIT])
    else $error("saturation flag not set");
  a_ovr_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    pend_reg[adcrb_pkg::EV_OVR_BIT] && !ev_clr[adcrb_pkg::EV_OVR_BIT]
    |=> pend_reg[adcrb_pkg::EV_OVR_BIT])
    else $error("overrun flag dropped without clear");
  a_ready_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept
    |=> pend_reg[adcrb_pkg::EV_READY_BIT])
    else $error("result ready flag not set");
  a_irq_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && en_reg[adcrb_pkg::EV_READY_BIT] && !(wr_acc && hit_en)
    |=> irq)
    else $error("enabled event missed interrupt");
  a_irq_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_reg == {adcrb_pkg::EV_W{1'h0}}
    |-> !irq)
    else $error("interrupt raised with all events disabled");
  a_run_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    result_valid && !run_reg
    |=> !ram_wr.en)
    else $error("result taken while converter stopped");

endmodule // adcrb_dma

// ==== rtl/adcrb_pkg.sv ====
package adcrb_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_EVENT_PENDING = 32'h4000A810;
  localparam logic [31:0] ADDR_EVENT_CLEAR = 32'h4000A830;
  localparam logic [31:0] ADDR_EVENT_ENABLE = 32'h4000A850;
  localparam logic [31:0] ADDR_CONV_CONTROL = 32'h4000D030;
  localparam logic [31:0] ADDR_BUF_CONTROL = 32'h4000D010;
  localparam logic [31:0] ADDR_BUF_STATE = 32'h4000D014;
  localparam logic [31:0] ADDR_BUF_START = 32'h4000D018;
  localparam logic [31:0] ADDR_BUF_LENGTH = 32'h4000D01C;
  localparam logic [31:0] ADDR_BUF_WPTR = 32'h4000D020;
  localparam logic [31:0] ADDR_BUF_COUNT = 32'h4000D024;

  // control field positions
  localparam int CTL_ARM_BIT = 0;
  localparam int CTL_WRAP_BIT = 1;
  localparam int CTL_RESET_BIT = 4;
  localparam int RUN_BIT = 0;

  // state field positions
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_DROPPED_BIT = 1;

  // event positions
  localparam int EV_READY_BIT = 0;
  localparam int EV_HALF_BIT = 1;
  localparam int EV_FULL_BIT = 2;
  localparam int EV_SAT_BIT = 3;
  localparam int EV_OVR_BIT = 4;
  localparam int EV_W = 5;

  // buffer geometry
  localparam int ADDR_W = 14;
  localparam int LEN_W = 13;
  localparam int DATA_W = 16;
  localparam logic [31:0] RAM_BASE = 32'h20000000;
  localparam logic [17:0] RAM_BASE_HI = 18'h08000;
  localparam logic [LEN_W-1:0] CNT_STEP = 13'h0001;
  localparam logic [LEN_W-1:0] CNT_ZERO = 13'h0000;

  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [DATA_W-1:0] data;
  } adcrb_ram_wr_t;

endpackage

// ==== sim/adcrb_partner.sv ====
`timescale 1ns/1ps
module adcrb_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_run,
  input wire logic gen,
  input wire adcrb_pkg::adcrb_ram_wr_t ram_wr,
  output logic result_valid,
  output logic [15:0] result_data,
  output logic [15:0] seq,
  output adcrb_pkg::adcrb_ram_wr_t last_wr,
  output logic [15:0] wr_total
);
  // results come only while the converter runs
  assign result_valid = conv_run & gen;
  // data line shows junk between results
  assign result_data = result_valid ? seq : ~seq;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= 16'h0100;
      last_wr <= '0;
      wr_total <= 16'h0000;
    end else begin
      if (result_valid) begin
        seq <= seq + 16'h0001;
      end
      if (ram_wr.en) begin
        last_wr <= ram_wr;
        wr_total <= wr_total + 16'h0001;
      end
    end
  end
endmodule // adcrb_partner

// ==== sim/adcrb_dma_bench.sv ====
`timescale 1ns/1ps
module adcrb_dma_bench;
  logic pclk, presetn, psel, penable, pwrite, gen, sat;
  logic [31:0] paddr, pwdata, prdata, rd_v;
  logic pready, pslverr, conv_run, irq, result_valid, rd_e;
  logic [15:0] result_data, seq, wr_total;
  adcrb_pkg::adcrb_ram_wr_t ram_wr, last_wr;
  int err_total = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  adcrb_dma u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_run(conv_run), .result_valid(result_valid),
    .result_data(result_data), .result_saturated(sat), .ram_wr(ram_wr),
    .irq(irq));
  adcrb_partner u_far (.pclk(pclk), .presetn(presetn), .gen(gen),
    .conv_run(conv_run), .ram_wr(ram_wr), .result_valid(result_valid),
    .result_data(result_data), .seq(seq), .last_wr(last_wr),
    .wr_total(wr_total));
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    checks++;
    if (s !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk($sformatf("reg %h", a), rd_v, x);
  endtask
  task automatic pulse(int n);
    @(posedge pclk);
    gen <= 1'b1;
    repeat (n) @(posedge pclk);
    gen <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset;
    rd(adcrb_pkg::ADDR_BUF_START, 32'h20000000);
    rd(adcrb_pkg::ADDR_BUF_WPTR, 32'h20000000);
    rd(adcrb_pkg::ADDR_BUF_COUNT, 32'h00000000);
    rd(adcrb_pkg::ADDR_EVENT_ENABLE, 32'h00000000);
    chk("conv_run", 32'(conv_run), 32'h00000000);
    apb(1'b1, adcrb_pkg::ADDR_BUF_STATE, 32'h00000003);
    chk("slverr", 32'(rd_e), 32'h00000001);
    rd(adcrb_pkg::ADDR_BUF_STATE, 32'h00000000);
    rd(32'h4000D0F0, 32'h00000000);
    chk("unmapped", 32'(rd_e), 32'h00000001);
    apb(1'b1, adcrb_pkg::ADDR_BUF_START, 32'h00000107);
    rd(adcrb_pkg::ADDR_BUF_START, 32'h20000106);
  endtask
  task automatic t_drop;
    apb(1'b1, adcrb_pkg::ADDR_CONV_CONTROL, 32'h00000001);
    rd(adcrb_pkg::ADDR_CONV_CONTROL, 32'h00000001);
    chk("conv_run", 32'(conv_run), 32'h00000001);
    pulse(1);
    rd(adcrb_pkg::ADDR_BUF_STATE, 32'h00000002);
    rd(adcrb_pkg::ADDR_EVENT_PENDING, 32'h00000010);
    apb(1'b1, adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000010);
    rd(adcrb_pkg::ADDR_BUF_STATE, 32'h00000000);
    rd(adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000000);
    apb(1'b1, adcrb_pkg::ADDR_EVENT_PENDING, 32'h0000001F);
  endtask
  task automatic t_linear;
    apb(1'b1, adcrb_pkg::ADDR_BUF_LENGTH, 32'h00000004);
    apb(1'b1, adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000000);
    rd(adcrb_pkg::ADDR_BUF_STATE, 32'h00000000);
    apb(1'b1, adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000001);
    repeat (2) @(posedge pclk);
    rd(adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000000);
    rd(adcrb_pkg::ADDR_BUF_STATE, 32'h00000001);
    pulse(4);
    chk("ram addr", last_wr.addr, 32'h2000010C);
    chk("ram data", 32'(last_wr.data), 32'(seq - 16'h0001));
    rd(adcrb_pkg::ADDR_BUF_COUNT, 32'h00000004);
    rd(adcrb_pkg::ADDR_BUF_WPTR, 32'h2000010E);
    rd(adcrb_pkg::ADDR_EVENT_PENDING, 32'h00000007);
    pulse(1);
    chk("ram writes", 32'(wr_total), 32'h00000004);
    rd(adcrb_pkg::ADDR_BUF_STATE, 32'h00000002);
  endtask
  task automatic t_wrap;
    apb(1'b1, adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000010);
    apb(1'b1, adcrb_pkg::ADDR_BUF_LENGTH, 32'h00000003);
    apb(1'b1, adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000003);
    repeat (2) @(posedge pclk);
    pulse(4);
    chk("ram addr", last_wr.addr, 32'h20000106);
    rd(adcrb_pkg::ADDR_BUF_WPTR, 32'h20000108);
    rd(adcrb_pkg::ADDR_BUF_COUNT, 32'h00000001);
    rd(adcrb_pkg::ADDR_BUF_STATE, 32'h00000001);
    apb(1'b1, adcrb_pkg::ADDR_BUF_CONTROL, 32'h00000010);
    rd(adcrb_pkg::ADDR_BUF_COUNT, 32'h00000000);
  endtask
  task automatic t_irq;
    apb(1'b1, adcrb_pkg::ADDR_EVENT_PENDING, 32'h0000001F);
    apb(1'b1, adcrb_pkg::ADDR_EVENT_ENABLE, 32'h00000008);
    sat <= 1'b1;
    @(posedge pclk);
    sat <= 1'b0;
    @(negedge pclk);
    chk("irq", 32'(irq), 32'h00000001);
    rd(adcrb_pkg::ADDR_EVENT_PENDING, 32'h00000008);
    apb(1'b1, adcrb_pkg::ADDR_EVENT_ENABLE, 32'h00000010);
    @(negedge pclk);
    chk("irq masked", 32'(irq), 32'h00000000);
    apb(1'b1, adcrb_pkg::ADDR_EVENT_ENABLE, 32'h00000008);
    apb(1'b1, adcrb_pkg::ADDR_EVENT_CLEAR, 32'h00000008);
    @(negedge pclk);
    chk("irq cleared", 32'(irq), 32'h00000000);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, gen, sat} = 7'h00;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_drop;
    t_linear;
    t_wrap;
    t_irq;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    finish_test;
  end
endmodule // adcrb_dma_bench
